//--- mrc_pkg.sv
// mrc_pkg: constants and types for the module reset controller
// assumes a 20 MHz core clock and a 21-pad control vector
package mrc_pkg;

	// core clock rate
	localparam int CLK_MHZ = 20;
	// reset pin to internal reset, least and longest delay
	localparam int RST_MIN_US = 1500;
	localparam int RST_MAX_US = 4000;
	// recommended host hold time on the reset pin
	localparam int HOST_HOLD_US = 5000;
	// low-frequency oscillator period, emulated by a divider
	localparam int LF_PERIOD_US = 500;
	localparam int LF_DIV_CYC = LF_PERIOD_US * CLK_MHZ;
	// consecutive high samples before the pin counts as asserted
	localparam int FILT_TICKS =
		(RST_MIN_US + LF_PERIOD_US - 1) / LF_PERIOD_US + 1;
	// stretch of an event-driven reset, in oscillator ticks
	localparam logic [3:0] HOLD_TICKS = 4'h2;

	// pad positions in the control vectors
	localparam int PAD_N = 21;
	localparam int PAD_GIO = 0;
	localparam int GIO_N = 6;
	localparam int PAD_PCM_IN = 6;
	localparam int PAD_PCM_SYNC = 7;
	localparam int PAD_PCM_CLK = 8;
	localparam int PAD_UART_RX = 9;
	localparam int PAD_UART_CTS = 10;
	localparam int PAD_USB_P = 11;
	localparam int PAD_USB_N = 12;
	localparam int PAD_SPI_CSB = 13;
	localparam int PAD_SPI_CLK = 14;
	localparam int PAD_SPI_MOSI = 15;
	localparam int PAD_PCM_OUT = 16;
	localparam int PAD_UART_TX = 17;
	localparam int PAD_UART_RTS = 18;
	localparam int PAD_SPI_MISO = 19;
	localparam int PAD_AIO = 20;

	// pad state forced while in reset
	localparam logic [PAD_N-1:0] PAD_RST_OE_N = 21'h0fffff;
	localparam logic [PAD_N-1:0] PAD_RST_OUT = 21'h000000;
	localparam logic [PAD_N-1:0] PAD_RST_PU = 21'h060000;
	localparam logic [PAD_N-1:0] PAD_RST_PD = 21'h09ffff;

	typedef struct packed {
		logic [PAD_N-1:0] oe_n;
		logic [PAD_N-1:0] out;
		logic [PAD_N-1:0] pu;
		logic [PAD_N-1:0] pd;
	} mrc_pad_t;

	localparam mrc_pad_t PAD_RST = '{PAD_RST_OE_N, PAD_RST_OUT,
		PAD_RST_PU, PAD_RST_PD};

	typedef struct packed {
		logic wdog;
		logic brk;
		logic pin;
		logic por;
	} mrc_cause_t;

	typedef enum logic [1:0] {
		ST_HOLD = 2'b01,
		ST_RUN = 2'b10
	} mrc_state_t;

endpackage

//--- mrc_pin_filter.sv
// mrc_pin_filter: qualifies the reset pin on low-frequency ticks
// assumes the pin is synchronous to clk and lf_tick is a 1-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module mrc_pin_filter
	import mrc_pkg::*;
#(
	parameter int TICKS = FILT_TICKS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lf_tick,
	input wire logic pin,
	output logic active
);

	localparam logic [3:0] T4 = 4'(TICKS);

	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic act_reg;
	logic act_next;

	initial begin
		if (TICKS < 1 || TICKS > 15) begin
			$error("filter tick count out of range");
		end
	end

	always_comb begin
		cnt_next = cnt_reg;
		if (lf_tick) begin
			if (!pin) begin
				cnt_next = 4'h0;
			end else if (cnt_reg != T4) begin
				cnt_next = cnt_reg + 4'h1;
			end
		end
		act_next = (cnt_next == T4);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 4'h0;
			act_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			act_reg <= act_next;
		end
	end

	assign active = act_reg;

	chk_pin_drop_clears: assert property (@(posedge clk)
		disable iff (!rst_n) (lf_tick && !pin) |=> !active)
		else $error("filtered pin stayed active after a low sample");

endmodule
`default_nettype wire

//--- mrc_top.sv
// mrc_top: gathers reset sources, drives core reset and pad states
// assumes all inputs synchronous to clk; func_pads from the running core
// Operation
// - reset comes from pin, power-on, serial break or watchdog expiry
// - reset pin is active high, filtered on low-frequency oscillator ticks
// - pin reset takes effect 1.5 ms to 4.0 ms after pin assertion
// - power-on detection holds the whole module in reset
// - in reset bidirectional pins are inputs, outputs three-stated
// - general lines and listed input pads: inputs with weak pull-down
// - audio data output three-state with weak pull-down in reset
// - serial transmit and request-to-send three-state, weak pull-up
// - spi data output three-state with weak pull-down in reset
// - analogue aux pin driven low as output during reset
`timescale 1ns/1ps
`default_nettype none
module mrc_top
	import mrc_pkg::*;
#(
	parameter int LF_DIV = LF_DIV_CYC,
	parameter int WDOG_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reset_pin_input,
	input wire logic por_active,
	input wire logic break_seen,
	input wire logic wdog_en,
	input wire logic [WDOG_W-1:0] wdog_limit,
	input wire logic wdog_kick,
	input wire mrc_pad_t func_pads,
	output logic core_rst_n,
	output mrc_pad_t pads,
	output mrc_cause_t rst_cause
);

	localparam logic [15:0] DIV_LAST = 16'(LF_DIV - 1);
	localparam logic [WDOG_W-1:0] WD_ONE = WDOG_W'(1);

	initial begin
		if (LF_DIV < 2 || LF_DIV > 65536) begin
			$error("oscillator divider out of range");
		end
		if (FILT_TICKS * LF_PERIOD_US > RST_MAX_US) begin
			$error("pin filter too slow for the longest delay");
		end
		if (WDOG_W < 1 || WDOG_W > 32) begin
			$error("watchdog width out of range");
		end
	end

	// low-frequency oscillator tick
	logic [15:0] div_reg;
	logic [15:0] div_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		tick_next = (div_reg == DIV_LAST);
		div_next = tick_next ? 16'h0000 : div_reg + 16'h0001;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	// filtered reset pin
	logic pin_active;

	mrc_pin_filter #(
		.TICKS(FILT_TICKS)
	) u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.lf_tick(tick_reg),
		.pin(reset_pin_input),
		.active(pin_active)
	);

	// watchdog, counted in oscillator ticks
	logic [WDOG_W-1:0] wd_reg;
	logic [WDOG_W-1:0] wd_next;
	logic fire_reg;
	logic fire_next;
	logic core_rst_n_reg;

	always_comb begin
		wd_next = wd_reg;
		fire_next = 1'b0;
		if (!core_rst_n_reg || !wdog_en || wdog_kick) begin
			wd_next = '0;
		end else if (tick_reg) begin
			if (wd_reg == wdog_limit) begin
				fire_next = 1'b1;
				wd_next = '0;
			end else begin
				wd_next = wd_reg + WD_ONE;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_reg <= '0;
			fire_reg <= 1'b0;
		end else begin
			wd_reg <= wd_next;
			fire_reg <= fire_next;
		end
	end

	// reset sequencing
	mrc_state_t state_reg;
	mrc_state_t state_next;
	logic [3:0] hold_reg;
	logic [3:0] hold_next;
	mrc_cause_t cause_reg;
	mrc_cause_t cause_next;
	mrc_cause_t src;
	logic level_src;
	logic event_src;
	logic core_rst_n_next;
	mrc_pad_t pads_reg;
	mrc_pad_t pads_next;

	always_comb begin
		src = '{fire_reg, break_seen, pin_active, por_active};
		level_src = por_active | pin_active;
		event_src = break_seen | fire_reg;
		state_next = state_reg;
		hold_next = hold_reg;
		cause_next = cause_reg;
		case (state_reg)
			ST_RUN: begin
				if (level_src || event_src) begin
					state_next = ST_HOLD;
					hold_next = HOLD_TICKS;
					cause_next = src;
				end
			end
			ST_HOLD: begin
				cause_next = cause_reg | src;
				if (event_src) begin
					hold_next = HOLD_TICKS;
				end else if (tick_reg && hold_reg != 4'h0) begin
					hold_next = hold_reg - 4'h1;
				end
				if (!level_src && !event_src && hold_reg == 4'h0) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_HOLD;
			end
		endcase
		core_rst_n_next = (state_next == ST_RUN);
		// pads forced while reset is active
		pads_next = core_rst_n_next ? func_pads : PAD_RST;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_HOLD;
			hold_reg <= 4'h0;
			cause_reg <= '0;
			core_rst_n_reg <= 1'b0;
			pads_reg <= PAD_RST;
		end else begin
			state_reg <= state_next;
			hold_reg <= hold_next;
			cause_reg <= cause_next;
			core_rst_n_reg <= core_rst_n_next;
			pads_reg <= pads_next;
		end
	end

	assign core_rst_n = core_rst_n_reg;
	assign pads = pads_reg;
	assign rst_cause = cause_reg;

	// checking helpers: consecutive pin-high cycles
	int hi_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_cnt <= 0;
		end else if (!reset_pin_input) begin
			hi_cnt <= 0;
		end else if (hi_cnt < 1000000000) begin
			hi_cnt <= hi_cnt + 1;
		end
	end

	chk_pin_min_delay: assert property (@(posedge clk)
		disable iff (!rst_n)
		$rose(pin_active) |-> hi_cnt >= (FILT_TICKS - 1) * LF_DIV)
		else $error("pin reset recognised too early");
	chk_pin_max_delay: assert property (@(posedge clk)
		disable iff (!rst_n)
		!pin_active |-> hi_cnt <= FILT_TICKS * LF_DIV + 2)
		else $error("pin reset recognised too late");
	chk_por_holds: assert property (@(posedge clk)
		disable iff (!rst_n)
		por_active |=> !core_rst_n)
		else $error("core left reset during power-on");
	chk_break_reset: assert property (@(posedge clk)
		disable iff (!rst_n)
		break_seen |=> !core_rst_n ##1 !core_rst_n)
		else $error("serial break did not reset");
	chk_wdog_reset: assert property (@(posedge clk)
		disable iff (!rst_n)
		(core_rst_n && wdog_en && !wdog_kick && tick_reg &&
		wd_reg == wdog_limit) |-> ##2 !core_rst_n && rst_cause.wdog)
		else $error("watchdog expiry did not reset");
	chk_sync_release: assert property (@(posedge clk)
		disable iff (!rst_n)
		$rose(core_rst_n) |-> !$past(por_active) &&
		!$past(pin_active) && !$past(break_seen) && !$past(fire_reg))
		else $error("reset released with a source active");
	chk_bidir_inputs: assert property (@(posedge clk)
		disable iff (!rst_n)
		!core_rst_n |-> &pads.oe_n[PAD_SPI_MISO:0])
		else $error("pad driven during reset");
	chk_gio_pulldown: assert property (@(posedge clk)
		disable iff (!rst_n)
		!core_rst_n |-> &pads.pd[PAD_SPI_MOSI:PAD_GIO] &&
		pads.pu[PAD_SPI_MOSI:PAD_GIO] == '0)
		else $error("input pad lacks pull-down in reset");
	chk_pcm_out_tri: assert property (@(posedge clk)
		disable iff (!rst_n)
		!core_rst_n |-> pads.oe_n[PAD_PCM_OUT] && pads.pd[PAD_PCM_OUT])
		else $error("audio output not three-stated");
	chk_uart_pullup: assert property (@(posedge clk)
		disable iff (!rst_n)
		!core_rst_n |-> &pads.pu[PAD_UART_RTS:PAD_UART_TX] &&
		&pads.oe_n[PAD_UART_RTS:PAD_UART_TX])
		else $error("serial outputs lack pull-up");
	chk_miso_tri: assert property (@(posedge clk)
		disable iff (!rst_n)
		!core_rst_n |-> pads.oe_n[PAD_SPI_MISO] && pads.pd[PAD_SPI_MISO])
		else $error("spi output not three-stated");
	chk_aio_low: assert property (@(posedge clk)
		disable iff (!rst_n)
		!core_rst_n |-> !pads.oe_n[PAD_AIO] && !pads.out[PAD_AIO])
		else $error("analogue pin not driven low");

	cov_pin_reset: cover property (@(posedge clk) disable iff (!rst_n)
		core_rst_n ##1 !core_rst_n && rst_cause.pin);
	cov_break_reset: cover property (@(posedge clk) disable iff (!rst_n)
		core_rst_n && break_seen ##1 !core_rst_n);
	cov_wdog_reset: cover property (@(posedge clk) disable iff (!rst_n)
		fire_reg ##1 !core_rst_n);
	cov_release: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(core_rst_n));

endmodule
`default_nettype wire

//--- mrc_host_model.sv
// mrc_host_model: host side driving the module reset pin
// assumes go is a one-cycle request sampled on clk
`timescale 1ns/1ps
`default_nettype none
module mrc_host_model
	import mrc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [15:0] hold_cyc,
	output logic pin
);
	logic [15:0] cnt_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
		end else if (go) begin
			cnt_reg <= hold_cyc;
		end else if (cnt_reg != 16'h0000) begin
			cnt_reg <= cnt_reg - 16'h0001;
		end
	end
	assign pin = (cnt_reg != 16'h0000);
endmodule
`default_nettype wire

//--- mrc_top_test.sv
// mrc_top_test: self-checking bench for the reset controller
// assumes a shortened oscillator divider; expectations scale with it
`timescale 1ns/1ps
`default_nettype none
module mrc_top_test
	import mrc_pkg::*;
;
	localparam int LF = 10;
	localparam int US_CYC = LF_PERIOD_US / LF;
	localparam int PIN_MIN = RST_MIN_US / US_CYC;
	localparam int PIN_MAX = RST_MAX_US / US_CYC;
	localparam int HOLD_CYC = HOST_HOLD_US / US_CYC + 1;
	logic clk, rst_n, por, brk, wen, kick, go, pin, core_rst_n;
	logic [15:0] wlim, hold;
	mrc_pad_t fp, pads;
	mrc_cause_t cause;
	int n_fail, checks_done, n, lim;
	integer seed;

	mrc_top #(.LF_DIV(LF), .WDOG_W(16)) uut (.clk(clk), .rst_n(rst_n),
		.reset_pin_input(pin), .por_active(por), .break_seen(brk),
		.wdog_en(wen), .wdog_limit(wlim), .wdog_kick(kick),
		.func_pads(fp), .core_rst_n(core_rst_n), .pads(pads),
		.rst_cause(cause));
	mrc_host_model host (.clk(clk), .rst_n(rst_n), .go(go),
		.hold_cyc(hold), .pin(pin));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// pad state in reset, built from the pad table
	function automatic mrc_pad_t rst_pads();
		mrc_pad_t p;
		p = '0;
		for (int i = 0; i < PAD_N; i++) begin
			p.oe_n[i] = (i != PAD_AIO);
			p.pu[i] = (i inside {PAD_UART_TX, PAD_UART_RTS});
			p.pd[i] = !(i inside {PAD_UART_TX, PAD_UART_RTS, PAD_AIO});
		end
		return p;
	endfunction

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [83:0] exp,
		input logic [83:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic chk_range(input string what, input int lo, input int hi,
		input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("unexpected %s: expected %0d..%0d, seen %0d", what, lo,
				hi, got);
		end
	endtask

	// counts falling edges until core reset shows val
	task automatic wait_core(input logic val, input int maxc, output int cnt);
		cnt = 0;
		while (core_rst_n !== val) begin
			@(negedge clk);
			cnt++;
			if (cnt > maxc) begin
				n_fail++;
				$display("unexpected core reset wait: expected %b, seen %b",
					val, core_rst_n);
				print_verdict();
			end
		end
	endtask

	task automatic stay_high(input int cyc);
		repeat (cyc) begin
			@(negedge clk);
			chk("core reset idle", 1'b1, core_rst_n);
		end
	endtask

	task automatic released();
		logic [95:0] r;
		r = {$random(seed), $random(seed), $random(seed)};
		@(posedge clk);
		fp <= r[83:0];
		wait_core(1'b1, 6 * LF, n);
		// core may already run: let one edge take the new pad word
		@(posedge clk);
		@(negedge clk);
		chk("pads running", fp, pads);
	endtask

	initial begin
		seed = 32'h20eebabb;
		{rst_n, brk, wen, kick, go} = 5'h00;
		por = 1'b1;
		wlim = 16'h0000;
		hold = 16'h0000;
		fp = '0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (20) @(posedge clk);
		@(negedge clk);
		chk("core por", 1'b0, core_rst_n);
		chk("pads por", rst_pads(), pads);
		chk("cause por", 4'h1, cause);
		@(posedge clk);
		por <= 1'b0;
		released();
		@(posedge clk);
		brk <= 1'b1;
		wait_core(1'b0, 4, n);
		chk_range("break delay", 2, 2, n);
		@(posedge clk);
		brk <= 1'b0;
		@(negedge clk);
		chk("cause break", 4'h4, cause);
		chk("pads break", rst_pads(), pads);
		released();
		@(posedge clk);
		go <= 1'b1;
		hold <= 16'(2 * LF);
		@(posedge clk);
		go <= 1'b0;
		stay_high(6 * LF);
		@(posedge clk);
		go <= 1'b1;
		hold <= 16'(HOLD_CYC);
		@(posedge clk);
		go <= 1'b0;
		wait_core(1'b0, PIN_MAX + 4, n);
		chk_range("pin delay", PIN_MIN, PIN_MAX + 1, n);
		chk("cause pin", 4'h2, cause);
		chk("pads pin", rst_pads(), pads);
		wait_core(1'b1, HOLD_CYC + 6 * LF, n);
		released();
		lim = 1 + ($unsigned($random(seed)) % 4);
		@(posedge clk);
		wlim <= 16'(lim);
		wen <= 1'b1;
		wait_core(1'b0, (lim + 2) * LF + 4, n);
		chk_range("wdog delay", lim * LF + 2, lim * LF + LF + 1, n);
		chk("cause wdog", 4'h8, cause);
		@(posedge clk);
		wen <= 1'b0;
		released();
		@(posedge clk);
		wen <= 1'b1;
		kick <= 1'b1;
		stay_high(8 * LF);
		print_verdict();
	end
endmodule
`default_nettype wire
